// ==== rtl/lacr_pkg.sv ====
// Package with constants and carrier types of the load-adaptive current regulator
package lacr_pkg;
	localparam int LOAD_W = 10;
	localparam int SCALE_W = 5;
	localparam int VEL_W = 23;
	localparam int THR_SHIFT = 5;
	localparam logic [SCALE_W-1:0] SCALE_RESET = 5'h1F;
	localparam int FILT_LEN = 4;
	localparam logic [1:0] FILT_LAST = 2'h3;

	// Configuration bundle written by host software
	typedef struct packed {
		logic [3:0] lower_load_threshold;
		logic [3:0] upper_threshold_offset;
		logic [1:0] current_increment_step;
		logic [1:0] decrement_measure_count;
		logic min_current_quarter;
		logic filter_enable;
		logic stop_on_stall_enable;
		logic load_commutation_mode;
		logic [SCALE_W-1:0] run_current_scale;
		logic [SCALE_W-1:0] standstill_current_scale;
		logic [VEL_W-1:0] regulation_low_velocity;
		logic [VEL_W-1:0] regulation_high_velocity;
	} lacr_cfg_type;

	// Load measurement event from the measurement front end
	typedef struct packed {
		logic valid;
		logic blocked;
		logic [LOAD_W-1:0] load_reading;
	} lacr_meas_type;
endpackage

// ==== rtl/lacr_filter.sv ====
// Four-sample averaging filter for load measurements
`timescale 1ns/1ps
`default_nettype none
module lacr_filter (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic enable,
	input wire logic in_valid,
	input wire logic [lacr_pkg::LOAD_W-1:0] in_load,
	output logic out_valid,
	output logic [lacr_pkg::LOAD_W-1:0] out_load
);
	import lacr_pkg::*;
	logic [1:0] cnt_q;
	logic [LOAD_W+1:0] sum_q;
	wire logic [LOAD_W+1:0] sum_next = sum_q + {2'h0, in_load};
	wire logic last = (cnt_q == FILT_LAST);

	// Accumulate four readings and emit their mean, or pass through when off
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 2'h0;
			sum_q <= '0;
			out_valid <= 1'b0;
			out_load <= '0;
		end else if (ce) begin
			out_valid <= 1'b0;
			if (in_valid && !enable) begin
				out_valid <= 1'b1;
				out_load <= in_load;
				cnt_q <= 2'h0;
				sum_q <= '0;
			end else if (in_valid) begin
				cnt_q <= cnt_q + 2'h1;
				sum_q <= last ? '0 : sum_next;
				if (last) begin
					out_valid <= 1'b1;
					out_load <= sum_next[LOAD_W+1:2];
				end
			end
		end
	end
endmodule // lacr_filter
`default_nettype wire

// ==== rtl/lacr_regulator.sv ====
// Load-adaptive current regulator for one stepper axis
// Operation
// - Lower setting zero disables regulation
// - Reading below setting*32 raises current
// - Upper threshold is (low+offset+1)*32
// - Increment step widths 1, 2, 4, 8
// - Decrement after 32, 8, 2, 1 readings
// - Minimum is half or quarter run scale
// - Below low velocity regulation is off
// - Above high velocity regulation is off
// - Actual current scale status is readable
// - Filter cuts regulation rate by four
// - Low velocity uses plain run/hold current
// - Zero reading with stop enabled stops motor
// - Commutation mode slows overloaded motor
// - Commutation mode flags a blocked motor
// - One load measurement per full step
// - Filter averages four measurements
// - Stop-on-stall bit makes ramp stop
`timescale 1ns/1ps
`default_nettype none
module lacr_regulator (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire lacr_pkg::lacr_cfg_type cfg,
	input wire lacr_pkg::lacr_meas_type meas,
	input wire logic [lacr_pkg::VEL_W-1:0] ramp_velocity,
	input wire logic standstill,
	input wire logic stall_clear,
	output logic [lacr_pkg::SCALE_W-1:0] actual_current_scale,
	output logic regulation_active,
	output logic stall_stop,
	output logic stall_flag,
	output logic velocity_reduce,
	output logic fullstep_select,
	output logic [lacr_pkg::LOAD_W-1:0] filtered_load
);
	import lacr_pkg::*;

	typedef enum logic [1:0] {
		ST_PLAIN = 2'b00,
		ST_REGULATE = 2'b01
	} lacr_state_type;

	lacr_state_type state_q, state_d;
	logic [SCALE_W-1:0] scale_q;
	logic [5:0] above_cnt_q;
	logic f_valid;
	logic [LOAD_W-1:0] f_load;

	// Each full-step measurement event enters the optional filter
	lacr_filter u_filter (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.ce(ce),
		.enable(cfg.filter_enable),
		.in_valid(meas.valid),
		.in_load(meas.load_reading),
		.out_valid(f_valid),
		.out_load(f_load)
	);

	// Thresholds and limits
	wire logic [LOAD_W:0] low_thr = {7'h00, cfg.lower_load_threshold} << THR_SHIFT;
	wire logic [LOAD_W:0] up_thr = ({6'h00, 1'b0, cfg.lower_load_threshold}
		+ {7'h00, cfg.upper_threshold_offset} + 11'h001) << THR_SHIFT;
	wire logic below_low = {1'b0, f_load} < low_thr;
	wire logic above_up = {1'b0, f_load} >= up_thr;
	wire logic [SCALE_W:0] run_plus = {1'b0, cfg.run_current_scale} + 6'h01;
	wire logic [SCALE_W:0] min_sum = cfg.min_current_quarter ? (run_plus >> 2) : (run_plus >> 1);
	wire logic [SCALE_W-1:0] min_scale = (min_sum == 6'h00) ? 5'h00 : 5'(min_sum - 6'h01);
	wire logic [4:0] inc_step = 5'h01 << cfg.current_increment_step;
	wire logic [5:0] dec_need = (cfg.decrement_measure_count == 2'h0) ? 6'h20 :
		(cfg.decrement_measure_count == 2'h1) ? 6'h08 :
		(cfg.decrement_measure_count == 2'h2) ? 6'h02 : 6'h01;

	// Regulation window
	wire logic vel_ok = !standstill && (ramp_velocity >= cfg.regulation_low_velocity)
		&& (ramp_velocity <= cfg.regulation_high_velocity);
	wire logic reg_en = (cfg.lower_load_threshold != 4'h0) && vel_ok && !cfg.load_commutation_mode;

	// Saturating arithmetic
	wire logic [SCALE_W:0] inc_sum = {1'b0, scale_q} + {1'b0, inc_step};
	wire logic [SCALE_W-1:0] inc_val = (inc_sum > {1'b0, cfg.run_current_scale}) ?
		cfg.run_current_scale : inc_sum[SCALE_W-1:0];
	wire logic [SCALE_W-1:0] dec_val = (scale_q > min_scale) ? scale_q - 5'h01 : min_scale;
	wire logic [5:0] above_next = above_cnt_q + 6'h01;
	wire logic dec_fire = f_valid && above_up && (above_next >= dec_need);
	wire logic [SCALE_W-1:0] plain_scale = standstill ? cfg.standstill_current_scale
		: cfg.run_current_scale;
	wire logic stall_evt = f_valid && (f_load == '0);

	// State choice
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_PLAIN: if (reg_en) begin
				state_d = ST_REGULATE;
			end
			ST_REGULATE: if (!reg_en) begin
				state_d = ST_PLAIN;
			end
			default: state_d = ST_PLAIN;
		endcase
	end

	// State and current scale
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_PLAIN;
			scale_q <= SCALE_RESET;
			above_cnt_q <= 6'h00;
		end else if (ce) begin
			state_q <= state_d;
			if (state_q != ST_REGULATE || !reg_en) begin
				scale_q <= plain_scale;
				above_cnt_q <= 6'h00;
			end else if (f_valid) begin
				if (scale_q > cfg.run_current_scale) begin
					scale_q <= cfg.run_current_scale;
				end else if (scale_q < min_scale) begin
					scale_q <= min_scale;
				end else if (below_low) begin
					scale_q <= inc_val;
				end else if (dec_fire) begin
					scale_q <= dec_val;
				end
				above_cnt_q <= (!above_up || dec_fire) ? 6'h00 : above_next;
			end
		end
	end

	// Status outputs and stall handling
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			actual_current_scale <= SCALE_RESET;
			regulation_active <= 1'b0;
			stall_stop <= 1'b0;
			stall_flag <= 1'b0;
			velocity_reduce <= 1'b0;
			fullstep_select <= 1'b0;
			filtered_load <= '0;
		end else if (ce) begin
			actual_current_scale <= scale_q;
			regulation_active <= (state_d == ST_REGULATE); // Follows the window with one register, like fullstep_select
			fullstep_select <= ramp_velocity > cfg.regulation_high_velocity;
			velocity_reduce <= cfg.load_commutation_mode && meas.valid && meas.blocked == 1'b0
				&& meas.load_reading == '0;
			if (f_valid) begin
				filtered_load <= f_load;
			end
			if (cfg.stop_on_stall_enable && (stall_evt ||
				(cfg.load_commutation_mode && meas.valid && meas.blocked))) begin
				stall_stop <= 1'b1;
			end else if (stall_clear) begin
				stall_stop <= 1'b0;
			end
			if (cfg.load_commutation_mode && meas.valid && meas.blocked) begin
				stall_flag <= 1'b1;
			end else if (stall_clear) begin
				stall_flag <= 1'b0;
			end
		end
	end
endmodule // lacr_regulator
`default_nettype wire

// ==== verification/lacr_regulator_checker.sv ====
// Port checker of the load-adaptive current regulator
`timescale 1ns/1ps
`default_nettype none
module lacr_regulator_checker (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire lacr_pkg::lacr_cfg_type cfg,
	input wire logic [lacr_pkg::VEL_W-1:0] ramp_velocity,
	input wire logic stall_clear,
	input wire logic [lacr_pkg::SCALE_W-1:0] actual_current_scale,
	input wire logic regulation_active,
	input wire logic stall_stop,
	input wire logic velocity_reduce,
	input wire logic fullstep_select
);
	import lacr_pkg::*;
	// Floor of the regulated scale, half or quarter of run
	wire logic [5:0] lim = ((6'(cfg.run_current_scale) + 6'h1) >> (cfg.min_current_quarter ? 2 : 1)) - 6'h1;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Limits, gating and sticky stall stop bit
	chk_scale_top: assert property (regulation_active |-> actual_current_scale <= cfg.run_current_scale)
		else $error("above run");
	chk_scale_floor: assert property (regulation_active |-> 6'(actual_current_scale) >= lim)
		else $error("below floor");
	chk_zero_off: assert property (ce && cfg.lower_load_threshold == 4'h0 |=> !regulation_active)
		else $error("zero setting");
	chk_slow_off: assert property (ce && ramp_velocity < cfg.regulation_low_velocity |=> !regulation_active)
		else $error("slow");
	chk_fast_off: assert property (ce && ramp_velocity > cfg.regulation_high_velocity |=> !regulation_active && fullstep_select)
		else $error("fast");
	chk_stop_hold: assert property (stall_stop && !stall_clear |=> stall_stop)
		else $error("stop lost");
	chk_stop_cause: assert property ($rose(stall_stop) |-> cfg.stop_on_stall_enable)
		else $error("stop cause");
	chk_slow_pulse: assert property (velocity_reduce |=> !velocity_reduce)
		else $error("pulse");
	cover property (regulation_active ##1 $changed(actual_current_scale));
	cover property ($rose(stall_stop));
	cover property ($rose(fullstep_select));
endmodule // lacr_regulator_checker
bind lacr_regulator lacr_regulator_checker chk_u (.sys_clk, .nrst, .ce, .cfg, .ramp_velocity, .stall_clear,
	.actual_current_scale, .regulation_active, .stall_stop, .velocity_reduce, .fullstep_select);
`default_nettype wire

// ==== verification/lacr_motor_model.sv ====
// Motor and load front end model giving one reading per full step
`timescale 1ns/1ps
`default_nettype none
module lacr_motor_model (
	input wire logic sys_clk,
	input wire logic step,
	input wire logic jammed,
	input wire logic [lacr_pkg::LOAD_W-1:0] load,
	output lacr_pkg::lacr_meas_type meas
);
	import lacr_pkg::*;
	initial meas = '0;
	// One pulse per step; the stale reading is scrambled between steps
	always @(posedge sys_clk) begin
		meas.valid <= step;
		meas.blocked <= jammed;
		meas.load_reading <= step ? load : ~meas.load_reading;
	end
endmodule // lacr_motor_model
`default_nettype wire

// ==== verification/load_adaptive_current_regulator_bench.sv ====
// Self-checking bench of the load-adaptive current regulator
`timescale 1ns/1ps
`default_nettype none
module load_adaptive_current_regulator_bench;
	import lacr_pkg::*;
	logic sys_clk, nrst, sst, clr, step, jam, act, stop, flag, fs;
	logic [LOAD_W-1:0] load, fload;
	logic vr;
	int vr_cnt = 0;
	logic [VEL_W-1:0] vel;
	logic [SCALE_W-1:0] scale, expd;
	lacr_cfg_type cfg;
	lacr_meas_type meas;
	int num_errors = 0, samples_checked = 0, c;
	lacr_motor_model mot_u (.sys_clk(sys_clk), .step(step), .jammed(jam), .load(load), .meas(meas));
	lacr_regulator dut_u (.sys_clk(sys_clk), .nrst(nrst), .ce(1'b1), .cfg(cfg), .meas(meas), .ramp_velocity(vel),
		.standstill(sst), .stall_clear(clr), .actual_current_scale(scale), .regulation_active(act),
		.stall_stop(stop), .stall_flag(flag), .velocity_reduce(vr), .fullstep_select(fs), .filtered_load(fload));
	// Count one-cycle slow-down pulses so they are not missed between compares
	always @(posedge sys_clk) begin
		if (vr === 1'b1) vr_cnt++;
	end
	// Clock of 100 ns
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// Value compare
	task check(input logic [4:0] got, input logic [4:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Load value compare
	task check_load(input logic [9:0] got, input logic [9:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: load got %h want %h", $time, got, exp);
		end
	endtask
	// Full steps with one load reading each, then the answer latency
	task steps(input logic [9:0] l, input int n);
		repeat (n) begin
			load = l;
			step = 1'b1;
			@(negedge sys_clk) step = 1'b0;
			repeat (5) @(negedge sys_clk);
		end
	endtask
	// Counts and verdict
	task summarize;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		{nrst, sst, clr, step, jam, load, vel} = {5'h0, 10'h0, 23'h1F4};
		cfg = '{4'h2, 4'h1, 2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 5'h1F, 5'h08, 23'h64, 23'h3E8};
		repeat (2) @(negedge sys_clk);
		check(scale, 5'h1F);
		nrst = 1'b1;
		steps(10'h080, 17);
		check(scale, 5'h0F);
		steps(10'h040, 1);
		check(scale, 5'h0F);
		expd = 5'h0F;
		for (c = 0; c < 5; c++) begin
			cfg.current_increment_step = (c > 3) ? 2'h3 : 2'(c);
			steps(10'h03F, 1);
			expd = (int'(expd) + (1 << cfg.current_increment_step) > 31) ? 5'h1F : expd + (5'h1 << cfg.current_increment_step);
			check(scale, expd);
		end
		cfg.decrement_measure_count = 2'h2;
		steps(10'h080, 1);
		steps(10'h07F, 1);
		steps(10'h080, 1);
		check(scale, 5'h1F);
		steps(10'h080, 1);
		check(scale, 5'h1E);
		{cfg.decrement_measure_count, cfg.filter_enable} = 3'h7;
		steps(10'h0C8, 8);
		check(scale, 5'h1C);
		check_load(fload, 10'h0C8);
		{cfg.filter_enable, cfg.lower_load_threshold} = 5'h0;
		repeat (4) @(negedge sys_clk);
		check(5'(act), 5'h0);
		check(scale, 5'h1F);
		{cfg.lower_load_threshold, vel, sst} = {4'h2, 23'h32, 1'b1};
		repeat (4) @(negedge sys_clk);
		check(5'(act), 5'h0);
		check(scale, 5'h08);
		{vel, sst} = {23'h7D0, 1'b0};
		repeat (4) @(negedge sys_clk);
		check({3'h0, act, fs}, 5'h1);
		{vel, cfg.stop_on_stall_enable} = {23'h1F4, 1'b1};
		steps(10'h000, 1);
		check(5'(stop), 5'h1);
		clr = 1'b1;
		@(negedge sys_clk) clr = 1'b0;
		{cfg.load_commutation_mode, jam} = 2'h3;
		steps(10'h000, 1);
		check(5'(flag), 5'h1);
		jam = 1'b0;
		vr_cnt = 0;
		steps(10'h000, 1);
		check(5'(vr_cnt), 5'h1);
		summarize();
	end
endmodule // load_adaptive_current_regulator_bench
`default_nettype wire
